// ### pkg/dwd_defs.vh
// Purpose: constants for the watchdog downcounter block
// Assumes: 40 MHz core clock, one step per prescale interval
// Notes:   included by bare name
`ifndef DWD_DEFS_VH
`define DWD_DEFS_VH
// ***********************************
// Register map
// ***********************************
`define DWD_REG_ADDR      8'hD8
`define DWD_REG_RESET     8'hFE
`define DWD_BIT_ACT       0
`define DWD_BIT_SRST      1
// ***********************************
// Timing
// ***********************************
`define DWD_PRESCALE      12'hC00
`define DWD_PRESCALE_W    12
`define DWD_GRACE_INSTR   8'h1C
`define DWD_STAB_CYCLES   16'h1000
`endif

// ### rtl/dwd_prescaler.v
// Purpose: one-cycle step pulse every prescale interval
// Assumes: synchronous active-low reset
// Notes:   frozen while hold is high, resumes from held count
`timescale 1ns/1ps
`default_nettype none
`include "dwd_defs.vh"
module dwd_prescaler (
   input  wire        clock,
   input  wire        rstn,
   input  wire        hold,
   input  wire        restart,
   output reg         step
);
   reg [`DWD_PRESCALE_W-1:0] cnt_q;
   always @(posedge clock) begin
      if (!rstn) begin
         cnt_q <= {`DWD_PRESCALE_W{1'b0}};
         step  <= 1'b0;
      end else if (restart) begin
         // Reload restarts the interval so periods are exact
         cnt_q <= {`DWD_PRESCALE_W{1'b0}};
         step  <= 1'b0;
      end else if (hold) begin
         step  <= 1'b0;
      end else if (cnt_q == `DWD_PRESCALE - 12'h001) begin
         cnt_q <= {`DWD_PRESCALE_W{1'b0}};
         step  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 12'h001;
         step  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### rtl/dwd_reset_gen.v
// Purpose: stretches a watchdog trip into a full device reset
// Assumes: trip is a level on the core clock, acted on only while reset_req is low
// Notes:   same delay as the external reset pin path
`timescale 1ns/1ps
`default_nettype none
`include "dwd_defs.vh"
module dwd_reset_gen (
   input  wire        clock,
   input  wire        rstn,
   input  wire        trip,
   output reg         reset_req
);
   reg [15:0] cnt_q;
   always @(posedge clock) begin
      if (!rstn) begin
         cnt_q     <= 16'h0000;
         reset_req <= 1'b0;
      end else if (trip && !reset_req) begin
         cnt_q     <= `DWD_STAB_CYCLES;
         reset_req <= 1'b1;
      end else if (reset_req) begin
         if (cnt_q == 16'h0001) begin
            reset_req <= 1'b0;
         end
         cnt_q <= cnt_q - 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ### rtl/dwd_watchdog.v
// Purpose: 7-bit reloadable watchdog downcounter with control register
// Assumes: one data-space register port from the core, options as straps
// Notes:   strap options sampled while rstn is low
`timescale 1ns/1ps
`default_nettype none
`include "dwd_defs.vh"
module dwd_watchdog (
   input  wire        clock,
   input  wire        rstn,
   input  wire        opt_hw_activate,
   input  wire        opt_ext_stop,
   input  wire        nmi_pin,
   input  wire        stop_exec,
   input  wire        wake,
   input  wire        instr_done,
   input  wire [7:0]  reg_addr,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   output reg         wd_reset,
   output reg         osc_stop,
   output reg         stop_as_wait
);
   // ***********************************
   // Register bit order conversion
   // ***********************************
   function [5:0] rev6;
      input [5:0] v;
      integer i;
      begin
         for (i = 0; i < 6; i = i + 1) begin
            rev6[i] = v[5-i];
         end
      end
   endfunction

   // ***********************************
   // Pin synchroniser and straps
   // ***********************************
   reg        nmi_s1_q;
   reg        nmi_s2_q;
   reg        hw_opt_q;
   reg        ext_opt_q;
   reg [6:0]  cnt_q;
   reg        act_q;
   reg        frozen_q;
   reg [7:0]  grace_q;
   reg        trip_q;
   wire       step;
   wire       reset_req;
   wire       sel;
   wire       wr_hit;
   wire       grace_done;
   wire       act_now;

   always @(posedge clock) begin
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
   end

   // Straps are levels; caught by clock while reset holds
   always @(posedge clock) begin
      if (!rstn) begin
         hw_opt_q  <= opt_hw_activate;
         ext_opt_q <= opt_ext_stop;
      end
   end

   assign sel        = (reg_addr == `DWD_REG_ADDR);
   assign wr_hit     = reg_wr && sel;
   assign grace_done = (grace_q == 8'h00);
   assign act_now    = act_q || hw_opt_q;

   // ***********************************
   // Stop mode handling
   // ***********************************
   always @(posedge clock) begin
      if (!rstn) begin
         frozen_q     <= 1'b0;
         osc_stop     <= 1'b0;
         stop_as_wait <= 1'b0;
      end else if (wake) begin
         frozen_q     <= 1'b0;
         osc_stop     <= 1'b0;
         stop_as_wait <= 1'b0;
      end else if (stop_exec) begin
         if (act_now && ext_opt_q && nmi_s2_q) begin
            frozen_q <= 1'b1;
            osc_stop <= 1'b1;
         end else if (act_now) begin
            // Oscillator must keep running for the counter
            stop_as_wait <= 1'b1;
         end else begin
            osc_stop <= 1'b1;
         end
      end
   end

   dwd_prescaler u_pre (
      .clock   (clock),
      .rstn    (rstn),
      .hold    (frozen_q),
      .restart (wr_hit),
      .step    (step)
   );

   // ***********************************
   // Counter and control register
   // ***********************************
   always @(posedge clock) begin
      if (!rstn) begin
         cnt_q <= 7'h7F;
         act_q <= 1'b0;
      end else if (wr_hit) begin
         cnt_q <= {reg_wdata[`DWD_BIT_SRST], rev6(reg_wdata[7:2])};
         act_q <= act_q | reg_wdata[`DWD_BIT_ACT];
      end else if (step && !frozen_q) begin
         cnt_q <= cnt_q - 7'h01;
      end
   end

   // Grace counter: instructions left after activation
   always @(posedge clock) begin
      if (!rstn) begin
         grace_q <= `DWD_GRACE_INSTR;
      end else if (wr_hit && reg_wdata[`DWD_BIT_ACT] && !act_now) begin
         grace_q <= `DWD_GRACE_INSTR;
      end else if (act_now && instr_done && !grace_done) begin
         grace_q <= grace_q - 8'h01;
      end
   end

   // Trip while bit 6 is low; held back until the grace window ends
   always @(posedge clock) begin
      if (!rstn) begin
         trip_q <= 1'b0;
      end else begin
         trip_q <= act_now && !cnt_q[6] && grace_done;
      end
   end

   dwd_reset_gen u_rst (
      .clock     (clock),
      .rstn      (rstn),
      .trip      (trip_q),
      .reset_req (reset_req)
   );

   always @(posedge clock) begin
      if (!rstn) begin
         wd_reset  <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         wd_reset <= reset_req;
         if (reg_rd && sel) begin
            reg_rdata <= {rev6(cnt_q[5:0]), cnt_q[6], act_now};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/dwd_props.sv
// Purpose: port checks for the watchdog block
// Assumes: straps change only while rstn is low
// Notes:   stop latencies allowed up to three cycles
`timescale 1ns/1ps
`default_nettype none
module dwd_props (
   input wire logic       clock,
   input wire logic       rstn,
   input wire logic       opt_hw_activate,
   input wire logic       opt_ext_stop,
   input wire logic       nmi_pin,
   input wire logic       stop_exec,
   input wire logic       wake,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       wd_reset,
   input wire logic       osc_stop,
   input wire logic       stop_as_wait
);
   // ******************
   // Properties
   // ******************
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Four held samples clear the two-flop pin sync
   sequence s_lo;
      (opt_hw_activate && opt_ext_stop && !nmi_pin) [*4] ##0 stop_exec;
   endsequence
   sequence s_hi;
      (opt_hw_activate && opt_ext_stop && nmi_pin) [*4] ##0 stop_exec;
   endsequence
   a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not idle");
   a_bad_addr: assert property (reg_rd && reg_addr != 8'hD8
      |=> reg_rdata == 8'h00) else $error("bad address answered");
   a_hw_act: assert property (opt_hw_activate && reg_rd
      && reg_addr == 8'hD8 |=> reg_rdata[0]) else $error("act bit low");
   a_reset_len: assert property ($rose(wd_reset) |-> wd_reset [*8])
      else $error("reset pulse short");
   a_hw_nostop: assert property (opt_hw_activate && !opt_ext_stop
      |-> !osc_stop) else $error("stop not blocked");
   a_gate_wait: assert property (s_lo |=> ##[0:2] stop_as_wait)
      else $error("stop not taken as wait");
   a_gate_stop: assert property (s_hi |=> ##[0:2] osc_stop)
      else $error("true stop not entered");
   a_wake_run: assert property (wake && !stop_exec
      |=> ##[0:2] !osc_stop) else $error("stop not left on wake");
endmodule
`default_nettype wire

// ### sim/test_digital_watchdog_downcounter.sv
// Purpose: self-checking bench for the watchdog block
// Assumes: 40 MHz clock, straps set during reset
// Notes:   shortest count keeps trip runs near 3072 cycles
`timescale 1ns/1ps
`default_nettype none
module test_digital_watchdog_downcounter;
   logic clock = 0, rstn = 0, opt_hw_activate = 0, opt_ext_stop = 0;
   logic nmi_pin = 0, stop_exec = 0, wake = 0, instr_done = 0;
   logic reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 8'hD8, reg_wdata = 8'h00;
   wire [7:0] reg_rdata;
   wire wd_reset, osc_stop, stop_as_wait;
   integer miscompares = 0, total_checks = 0, i;
   logic [15:0] rows [0:3] = '{16'h8282, 16'h0606, 16'h0000, 16'hFEFE};
   always #12.5 clock = ~clock;
   dwd_watchdog u_dwd_watchdog (.*);
   // ******************
   // Tasks
   // ******************
   task chk(input [7:0] g, e);
      total_checks = total_checks + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task rst(input h, x);
      @(posedge clock);
      rstn <= 1'b0;
      opt_hw_activate <= h;
      opt_ext_stop <= x;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
   endtask
   // Read checks at the falling edge, data stands one cycle
   task acc(input w, input [7:0] a, d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      {reg_wr, reg_rd} <= {w, !w};
      @(posedge clock);
      {reg_wr, reg_rd} <= 2'b00;
      @(negedge clock);
      if (!w) chk(reg_rdata, d);
   endtask
   task pl(input integer k);
      @(posedge clock);
      {stop_exec, wake, instr_done} <= {k == 0, k == 1, k == 2};
      @(posedge clock);
      {stop_exec, wake, instr_done} <= 3'b000;
      repeat (3) @(posedge clock);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      rst(1'b0, 1'b0);
      acc(1'b0, 8'hD8, 8'hFE);
      acc(1'b0, 8'hD9, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         acc(1'b1, 8'hD8, rows[i][15:8]);
         acc(1'b0, 8'hD8, rows[i][7:0]);
      end
      chk(wd_reset, 1'b0);
      acc(1'b1, 8'hD8, 8'h80);
      repeat (3080) @(posedge clock);
      acc(1'b0, 8'hD8, 8'h00);
      acc(1'b1, 8'hD8, 8'h03);
      acc(1'b1, 8'hD8, 8'h02);
      acc(1'b0, 8'hD8, 8'h03);
      repeat (3200) @(posedge clock);
      acc(1'b0, 8'hD8, 8'hFD);
      chk(wd_reset, 1'b0);
      repeat (28) pl(2);
      repeat (3) @(posedge clock);
      chk(wd_reset, 1'b1);
      rst(1'b1, 1'b1);
      nmi_pin <= 1'b1;
      acc(1'b0, 8'hD8, 8'hFF);
      pl(0);
      chk(osc_stop, 1'b1);
      repeat (3200) @(posedge clock);
      acc(1'b0, 8'hD8, 8'hFF);
      nmi_pin <= 1'b0;
      pl(1);
      chk(osc_stop, 1'b0);
      pl(0);
      chk(stop_as_wait, 1'b1);
      rst(1'b1, 1'b0);
      pl(0);
      chk({osc_stop, stop_as_wait}, 8'h01);
      repeat (28) pl(2);
      chk(wd_reset, 1'b0);
      acc(1'b1, 8'hD8, 8'hFD);
      repeat (5) @(posedge clock);
      chk(wd_reset, 1'b1);
      close_out;
   end
endmodule
bind dwd_watchdog dwd_props u_dwd_props (.*);
`default_nettype wire
